/* File: src/nibble_bus_pkg.sv */
/*
  Shared constants of the nibble expansion bus: operation codes, controller
  port offsets, address categories and strobe timing.
  Assumes a single 125 MHz clock on both ends of the bus.
*/
package nibble_bus_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [2:0] op_t;
  typedef logic [3:0] cat_t;

  // ****************************************
  // operation codes on the select lines
  // ****************************************
  localparam op_t OP_RD_PRIMARY = 3'h0;
  localparam op_t OP_RD_SECONDARY = 3'h1;
  localparam op_t OP_RD_SPARE = 3'h2;
  localparam op_t OP_BUS_RESET = 3'h3;
  localparam op_t OP_ADR_FIRST = 3'h4;
  localparam op_t OP_ADR_SECOND = 3'h5;
  localparam op_t OP_ADR_THIRD = 3'h6;
  localparam op_t OP_WRITE = 3'h7;

  // ****************************************
  // controller port offsets
  // ****************************************
  localparam byte_t OFS_READ_DATA_PRIMARY = 8'hC0;
  localparam byte_t OFS_READ_DATA_SECONDARY = 8'hC2;
  localparam byte_t OFS_READ_DATA_SPARE = 8'hC4;
  localparam byte_t OFS_BUS_RESET_TRIGGER = 8'hC6;
  localparam byte_t OFS_ADDRESS_PHASE_FIRST = 8'hC8;
  localparam byte_t OFS_ADDRESS_PHASE_SECOND = 8'hCA;
  localparam byte_t OFS_ADDRESS_PHASE_THIRD = 8'hCC;
  localparam byte_t OFS_WRITE_DATA_PORT = 8'hCE;
  localparam logic [3:0] OFS_BASE_NIBBLE = 4'hC;

  // ****************************************
  // address categories
  // ****************************************
  localparam cat_t CAT_EXPANSION = 4'hB;
  localparam cat_t CAT_RESET = 4'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // address bits carried per phase for a category
  function automatic logic [3:0] cat_bits(input cat_t cat);
    logic [3:0] b;
    b = 4'h4;
    if (cat[3:2] == 2'b11) begin
      b = 4'h8;
    end else if ((cat >= 4'h4) && (cat <= 4'h7)) begin
      b = 4'h5;
    end else if ((cat >= 4'h8) && (cat <= 4'hA)) begin
      b = 4'h6;
    end
    return b;
  endfunction

  // number of address phases for a category
  function automatic logic [1:0] cat_phases(input cat_t cat);
    logic [1:0] p;
    p = 2'h3;
    if ((cat == 4'hA) || (cat == CAT_EXPANSION) || (cat == 4'hE) || (cat == 4'hF)) begin
      p = 2'h1;
    end else if (cat == 4'hC) begin
      p = 2'h2;
    end
    return p;
  endfunction

  // mask of significant data bits for a category
  function automatic byte_t cat_mask(input cat_t cat);
    return byte_t'(8'hFF >> (4'h8 - cat_bits(cat)));
  endfunction

  // true when the high data nibble carries information
  function automatic logic cat_uses_high(input cat_t cat);
    return cat_bits(cat) > 4'h4;
  endfunction

  function automatic logic op_is_read(input op_t op);
    return op <= OP_RD_SPARE;
  endfunction

endpackage

/* File: src/nibble_bus_if.sv */
/*
  Connector of the nibble expansion bus between controller and board.
  Assumes pull-ups on the data lines and the attention line.
*/
`timescale 1ns/1ps
interface nibble_bus_if;
  logic bus_strobe_n;
  logic [2:0] op_select_lines;
  logic [7:0] host_data_o;
  logic [1:0] host_data_oe;
  logic [7:0] dev_data_o;
  logic [1:0] dev_data_oe;
  logic attn_oe;
  logic [3:0] data_low_nibble;
  logic [3:0] data_high_nibble;
  logic attention_n;

  // ****************************************
  // wire resolution, undriven lines pull high
  // ****************************************
  assign data_low_nibble = dev_data_oe[0] ? dev_data_o[3:0] : (host_data_oe[0] ? host_data_o[3:0] : 4'hF);
  assign data_high_nibble = dev_data_oe[1] ? dev_data_o[7:4] : (host_data_oe[1] ? host_data_o[7:4] : 4'hF);
  assign attention_n = ~attn_oe;

  modport host (
    output bus_strobe_n,
    output op_select_lines,
    output host_data_o,
    output host_data_oe,
    input data_low_nibble,
    input data_high_nibble,
    input attention_n
  );

  modport board (
    input bus_strobe_n,
    input op_select_lines,
    input data_low_nibble,
    input data_high_nibble,
    output dev_data_o,
    output dev_data_oe,
    output attn_oe
  );
endinterface

/* File: src/nibble_bus_host.sv */
/*
  Controller end of the nibble expansion bus: turns port accesses at
  offsets C0..CE into strobed bus cycles.
  Assumes one request at a time from the user side and synchronous inputs.
*/
`timescale 1ns/1ps
module nibble_bus_host #(
  parameter int STROBE_CYCLES = nibble_bus_pkg::STROBE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  nibble_bus_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire nibble_bus_pkg::byte_t req_offset,
  input wire nibble_bus_pkg::byte_t req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output nibble_bus_pkg::byte_t rsp_rdata,
  output logic rsp_error,
  output logic wide_mode,
  output logic irq
);
  import nibble_bus_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_SETUP = 4'b0010,
    H_STROBE = 4'b0100,
    H_HOLD = 4'b1000
  } host_state_e;

  host_state_e st_q, st_d;
  logic strobe_q, strobe_d;
  op_t op_q, op_d;
  byte_t data_q, data_d;
  logic [1:0] oe_q, oe_d;
  logic write_q, write_d;
  logic [7:0] cnt_q, cnt_d;
  cat_t cat_q, cat_d;
  logic ready_q, ready_d;
  logic rsp_q, rsp_d;
  byte_t rdata_q, rdata_d;
  logic err_q, err_d;
  logic irq_q, irq_d;
  logic wide_q, wide_d;
  op_t req_op;
  logic ofs_ok;
  byte_t bus_data;

  assign req_op = req_offset[3:1];
  assign ofs_ok = (req_offset[7:4] == OFS_BASE_NIBBLE) && !req_offset[0];
  assign bus_data = {bus.data_high_nibble, bus.data_low_nibble};

  // ****************************************
  // access sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    strobe_d = strobe_q;
    op_d = op_q;
    data_d = data_q;
    oe_d = oe_q;
    write_d = write_q;
    cnt_d = cnt_q;
    cat_d = cat_q;
    rsp_d = 1'b0;
    rdata_d = rdata_q;
    err_d = err_q;
    irq_d = ~bus.attention_n;
    case (st_q)
      H_IDLE: begin
        if (req_valid && ready_q) begin
          err_d = 1'b0;
          // the bus reset port is reached by a read, like the data reads
          if (!ofs_ok || (req_write == (op_is_read(req_op) || (req_op == OP_BUS_RESET)))) begin
            err_d = 1'b1;
            st_d = H_HOLD;
          end else begin
            op_d = req_op;
            write_d = req_write;
            st_d = H_SETUP;
            if (req_write) begin
              data_d = req_wdata;
              // width follows the category of the first address byte
              if (req_op == OP_ADR_FIRST) begin
                cat_d = req_wdata[3:0];
                oe_d = {cat_uses_high(req_wdata[3:0]), 1'b1};
              end else begin
                oe_d = {cat_uses_high(cat_q), 1'b1};
              end
            end
          end
        end
      end
      H_SETUP: begin
        strobe_d = 1'b0;
        cnt_d = 8'(STROBE_CYCLES - 1);
        st_d = H_STROBE;
      end
      H_STROBE: begin
        if (cnt_q == 8'h00) begin
          strobe_d = 1'b1;
          st_d = H_HOLD;
          if (!write_q) begin
            rdata_d = cat_uses_high(cat_q) ? bus_data : {4'h0, bus_data[3:0]};
          end
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      H_HOLD: begin
        // op stays put through the strobe's trailing edge
        oe_d = 2'b00;
        rsp_d = 1'b1;
        st_d = H_IDLE;
      end
      default: begin
        st_d = H_IDLE;
        strobe_d = 1'b1;
        oe_d = 2'b00;
      end
    endcase
    ready_d = (st_d == H_IDLE) && !(st_q == H_IDLE && req_valid && ready_q);
    wide_d = cat_uses_high(cat_d);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= H_IDLE;
      strobe_q <= 1'b1;
      op_q <= OP_RD_PRIMARY;
      data_q <= 8'h00;
      oe_q <= 2'b00;
      write_q <= 1'b0;
      cnt_q <= 8'h00;
      cat_q <= CAT_RESET;
      ready_q <= 1'b0;
      rsp_q <= 1'b0;
      rdata_q <= 8'h00;
      err_q <= 1'b0;
      irq_q <= 1'b0;
      wide_q <= 1'b0;
    end else begin
      st_q <= st_d;
      strobe_q <= strobe_d;
      op_q <= op_d;
      data_q <= data_d;
      oe_q <= oe_d;
      write_q <= write_d;
      cnt_q <= cnt_d;
      cat_q <= cat_d;
      ready_q <= ready_d;
      rsp_q <= rsp_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      irq_q <= irq_d;
      wide_q <= wide_d;
    end
  end

  assign bus.bus_strobe_n = strobe_q;
  assign bus.op_select_lines = op_q;
  assign bus.host_data_o = data_q;
  assign bus.host_data_oe = oe_q;
  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign rsp_error = err_q;
  assign wide_mode = wide_q;
  assign irq = irq_q;
endmodule

/* File: src/nibble_bus_board.sv */
/*
  Expansion board end of the nibble expansion bus: chained address latches,
  expansion register, one data register and presence reply.
  Assumes the controller holds select lines and write data stable while the
  strobe is low; all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
// Behaviour
// - controller strobes and drives three select lines
// - attention open-drain, low means interrupt
// - bus width follows selected address encoding
// - eight operation codes at even ports C0-CE
// - reset operation resets every board
// - address phases written first, second, third
// - board latches its own address, stays selected
// - three chained latches, each needs earlier ones
// - narrow addressing: three nibbles, twelve bits
// - reserved address selects four-bit expansion register
// - first byte low nibble picks category
// - five-bit mode uses five bits per byte
// - no minimum spacing between accesses assumed
// - present narrow board reads bit 0 low
module nibble_bus_board #(
  parameter nibble_bus_pkg::byte_t MATCH_FIRST = 8'h00,
  parameter nibble_bus_pkg::byte_t MATCH_SECOND = 8'h00,
  parameter nibble_bus_pkg::byte_t MATCH_THIRD = 8'h00,
  parameter logic USE_EXPANSION = 1'b0,
  parameter logic [3:0] EXPANSION_MATCH = 4'h0
) (
  input wire logic clk,
  input wire logic nrst,
  nibble_bus_if.board bus,
  input wire nibble_bus_pkg::byte_t in_data,
  input wire logic attn_req,
  output nibble_bus_pkg::byte_t out_data,
  output logic wr_pulse,
  output logic rd_pulse,
  output logic bus_reset_pulse,
  output logic selected
);
  import nibble_bus_pkg::*;

  localparam cat_t BOARD_CAT = MATCH_FIRST[3:0];
  localparam logic [1:0] BOARD_PHASES = cat_phases(MATCH_FIRST[3:0]);
  localparam logic BOARD_WIDE = cat_uses_high(MATCH_FIRST[3:0]);
  localparam byte_t BOARD_MASK = cat_mask(MATCH_FIRST[3:0]);
  localparam byte_t MATCH_ALL [3] = '{MATCH_FIRST, MATCH_SECOND, MATCH_THIRD};

  // ****************************************
  // declarations
  // ****************************************
  logic strobe_prev_q, strobe_prev_d;
  logic [2:0] lat_q, lat_d;
  logic exp_sel_q, exp_sel_d;
  logic [3:0] exp_q, exp_d;
  byte_t out_q, out_d;
  byte_t drv_q, drv_d;
  logic [1:0] drv_oe_q, drv_oe_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic rst_q, rst_d;
  logic sel_q, sel_d;
  logic attn_q, attn_d;
  logic [2:0] phase_hit;
  logic fall;
  logic board_sel;
  logic exp_ok;
  op_t op;
  byte_t data;

  assign op = bus.op_select_lines;
  assign data = {bus.data_high_nibble, bus.data_low_nibble};
  // address, write, reset and read-pulse actions take the falling strobe, read data is driven one clock behind the strobe low time, so back-to-back cycles work
  assign fall = strobe_prev_q && !bus.bus_strobe_n;

  // ****************************************
  // per-phase address comparators
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      // only the category's own bits count in each phase
      assign phase_hit[gi] = ((data & BOARD_MASK) == (MATCH_ALL[gi] & BOARD_MASK));
    end
  endgenerate

  // ****************************************
  // selection state
  // ****************************************
  assign exp_ok = !USE_EXPANSION || (exp_q == EXPANSION_MATCH);
  assign board_sel = lat_q[BOARD_PHASES - 2'h1] && exp_ok;

  always_comb begin
    strobe_prev_d = bus.bus_strobe_n;
    lat_d = lat_q;
    exp_sel_d = exp_sel_q;
    exp_d = exp_q;
    out_d = out_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    rst_d = 1'b0;
    if (fall) begin
      case (op)
        OP_BUS_RESET: begin
          lat_d = 3'b000;
          exp_sel_d = 1'b0;
          exp_d = 4'h0;
          out_d = 8'h00;
          rst_d = 1'b1;
        end
        OP_ADR_FIRST: begin
          // a new first phase always restarts the chain
          lat_d = {2'b00, phase_hit[0]};
          exp_sel_d = (data[3:0] == CAT_EXPANSION);
        end
        OP_ADR_SECOND: begin
          lat_d[1] = lat_q[0] && phase_hit[1];
          lat_d[2] = 1'b0;
        end
        OP_ADR_THIRD: begin
          lat_d[2] = lat_q[0] && lat_q[1] && phase_hit[2];
        end
        OP_WRITE: begin
          if (exp_sel_q) begin
            exp_d = data[3:0];
          end else if (board_sel) begin
            out_d = BOARD_WIDE ? data : {4'h0, data[3:0]};
            wr_d = 1'b1;
          end
        end
        OP_RD_PRIMARY, OP_RD_SECONDARY, OP_RD_SPARE: begin
          rd_d = board_sel;
        end
        default: begin
          rd_d = 1'b0;
        end
      endcase
    end
    sel_d = board_sel;
  end

  // ****************************************
  // read drive
  // ****************************************
  always_comb begin
    drv_d = drv_q;
    drv_oe_d = 2'b00;
    if (!bus.bus_strobe_n && op_is_read(op) && board_sel) begin
      drv_oe_d = {BOARD_WIDE, 1'b1};
      case (op)
        OP_RD_PRIMARY: begin
          drv_d = in_data;
        end
        OP_RD_SECONDARY: begin
          drv_d = {in_data[7:1], 1'b0};
        end
        OP_RD_SPARE: begin
          drv_d = out_q;
        end
        default: begin
          drv_d = 8'hFF;
        end
      endcase
    end
  end

  // ****************************************
  // attention request
  // ****************************************
  always_comb begin
    attn_d = attn_req;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strobe_prev_q <= 1'b1;
      lat_q <= 3'b000;
      exp_sel_q <= 1'b0;
      exp_q <= 4'h0;
      out_q <= 8'h00;
      drv_q <= 8'h00;
      drv_oe_q <= 2'b00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rst_q <= 1'b0;
      sel_q <= 1'b0;
      attn_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      lat_q <= lat_d;
      exp_sel_q <= exp_sel_d;
      exp_q <= exp_d;
      out_q <= out_d;
      drv_q <= drv_d;
      drv_oe_q <= drv_oe_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      rst_q <= rst_d;
      sel_q <= sel_d;
      attn_q <= attn_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus.dev_data_o = drv_q;
  assign bus.dev_data_oe = drv_oe_q;
  assign bus.attn_oe = attn_q;
  assign out_data = out_q;
  assign wr_pulse = wr_q;
  assign rd_pulse = rd_q;
  assign bus_reset_pulse = rst_q;
  assign selected = sel_q;

  // unused category constant kept for readability of the width choice
  localparam cat_t BOARD_CAT_CHECK = BOARD_CAT;
endmodule

/* File: dv/nibble_bus_props.sv */
/*
  Checker of the nibble expansion bus wire between controller and board.
  Assumes clk and nrst of the controller and the bus signals as plain inputs.
*/
`timescale 1ns/1ps
module nibble_bus_props #(
  parameter int STROBE_CYCLES = 13
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_strobe_n,
  input wire logic [2:0] op_select_lines,
  input wire logic [7:0] host_data_o,
  input wire logic [1:0] host_data_oe,
  input wire logic [1:0] dev_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;

  // ****************************************
  // strobe low-time counter
  // ****************************************
  always_comb begin
    low_cnt_d = (!nrst || bus_strobe_n) ? 8'h00 : low_cnt_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    low_cnt_q <= low_cnt_d;
  end

  sequence s_strobe_end;
    $rose(bus_strobe_n);
  endsequence
  sequence s_write_phase;
    !bus_strobe_n && op_select_lines[2];
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  a_strobe_width: assert property (s_strobe_end |-> low_cnt_q == STROBE_CYCLES)
    else $error("strobe low time wrong");
  a_strobe_bounded: assert property (!bus_strobe_n |-> low_cnt_q < STROBE_CYCLES)
    else $error("strobe held low too long");
  a_setup_stable: assert property ($fell(bus_strobe_n) |-> $stable(op_select_lines) && $stable(host_data_oe))
    else $error("select lines not set up before strobe");
  a_op_hold: assert property (!bus_strobe_n |-> $stable(op_select_lines))
    else $error("select lines moved during strobe");
  a_write_data_hold: assert property (s_write_phase |-> host_data_oe[0] && $stable(host_data_o))
    else $error("write data not driven and held");
  a_read_lines_free: assert property (!bus_strobe_n && !op_select_lines[2] |-> host_data_oe == 2'b00)
    else $error("controller drives data during read");
  a_board_drive_window: assert property (|dev_data_oe |-> !$past(bus_strobe_n) && op_select_lines <= 3'h2)
    else $error("board drives outside a read strobe");
  a_data_release: assert property (s_strobe_end |-> ##1 host_data_oe == 2'b00)
    else $error("controller did not release data");
  a_no_contention: assert property (!(|(host_data_oe & dev_data_oe)))
    else $error("both ends drive data");
endmodule

/* File: dv/nibble_expansion_bus_host_test.sv */
/*
  Self-checking bench: controller and one narrow board joined by the bus.
  Assumes the design package, interface and both ends compiled before it.
*/
`timescale 1ns/1ps
module nibble_expansion_bus_host_test;
  import nibble_bus_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic attn_req = 1'b0;
  byte_t req_offset = 8'h00;
  byte_t req_wdata = 8'h00;
  byte_t in_data = 8'h00;
  byte_t rsp_rdata, out_data, rd, wd;
  logic req_ready, rsp_valid, rsp_error, wide_mode, irq, wr_pulse, rd_pulse, rst_pulse, selected, er;
  logic strobe_prev = 1'b1;
  op_t last_op;
  int n_errors = 0;
  int checks_done = 0;
  int n_strobe = 0;
  int n_wr = 0;
  int n_rst = 0;
  int n_rd = 0;
  int c0;
  int c1;

  nibble_bus_if bus_if();
  nibble_bus_host #(.STROBE_CYCLES(4)) u_nibble_bus_host (.clk(clk), .nrst(nrst), .bus(bus_if),
    .req_valid(req_valid), .req_write(req_write), .req_offset(req_offset), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
    .wide_mode(wide_mode), .irq(irq));
  nibble_bus_board #(.MATCH_FIRST(8'h01), .MATCH_SECOND(8'h05), .MATCH_THIRD(8'h0A)) u_nibble_bus_board (
    .clk(clk), .nrst(nrst), .bus(bus_if), .in_data(in_data), .attn_req(attn_req), .out_data(out_data),
    .wr_pulse(wr_pulse), .rd_pulse(rd_pulse), .bus_reset_pulse(rst_pulse), .selected(selected));
  nibble_bus_props #(.STROBE_CYCLES(4)) u_nibble_bus_props (.clk(clk), .nrst(nrst),
    .bus_strobe_n(bus_if.bus_strobe_n), .op_select_lines(bus_if.op_select_lines),
    .host_data_o(bus_if.host_data_o), .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));

  always #4 clk = ~clk;

  // ****************************************
  // bus monitor: strobes, op codes, pulses
  // ****************************************
  always @(negedge clk) begin
    if (strobe_prev && !bus_if.bus_strobe_n) begin
      n_strobe++;
      last_op = bus_if.op_select_lines;
    end
    strobe_prev = bus_if.bus_strobe_n;
    if (wr_pulse === 1'b1) n_wr++;
    if (rst_pulse === 1'b1) n_rst++;
    if (rd_pulse === 1'b1) n_rd++;
  end

  function automatic logic wide_exp(input cat_t c);
    return !((c <= 4'h3) || (c == 4'hB));
  endfunction

  task automatic chk(input string what, input byte_t exp, input byte_t got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // one request held until taken, then wait for the answer
  task automatic access(input logic w, input byte_t ofs, input byte_t d, input logic bad);
    int n;
    int s0;
    n = 0;
    s0 = n_strobe;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_offset = ofs;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    rd = rsp_rdata;
    er = rsp_error;
    chk("answer", 8'h01, {7'h0, n < 100});
    chk("rsp_error", {7'h0, bad}, {7'h0, er});
    chk("strobe count", bad ? 8'h00 : 8'h01, 8'(n_strobe - s0));
    if (!bad) chk("op code", {5'h0, ofs[3:1]}, {5'h0, last_op});
  endtask

  task automatic select(input byte_t a, input byte_t b, input byte_t c);
    access(1'b1, 8'hC8, a, 1'b0);
    access(1'b1, 8'hCA, b, 1'b0);
    access(1'b1, 8'hCC, c, 1'b0);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #160000;
    n_errors++;
    give_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(32'h430e));
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    access(1'b0, 8'hC1, 8'h00, 1'b1);
    access(1'b1, 8'hC0, 8'h00, 1'b1);
    access(1'b0, 8'hCA, 8'h00, 1'b1);
    access(1'b0, 8'h40, 8'h00, 1'b1);
    $display("test refusals done");
    select(8'h01, 8'h05, 8'h0A);
    chk("selected", 8'h01, {7'h0, selected});
    chk("wide mode", 8'h00, {7'h0, wide_mode});
    c0 = n_wr;
    c1 = n_rd;
    for (int i = 0; i < 4; i++) begin
      wd = byte_t'($urandom);
      in_data = byte_t'($urandom);
      access(1'b1, 8'hCE, wd, 1'b0);
      chk("board data", {4'h0, wd[3:0]}, out_data);
      access(1'b0, 8'hC4, 8'h00, 1'b0);
      chk("readback", {4'h0, wd[3:0]}, rd);
      access(1'b0, 8'hC2, 8'h00, 1'b0);
      chk("presence read", {4'h0, in_data[3:1], 1'b0}, rd);
      access(1'b0, 8'hC0, 8'h00, 1'b0);
      chk("data read", {4'h0, in_data[3:0]}, rd);
    end
    chk("write pulses", 8'h04, 8'(n_wr - c0));
    chk("read pulses", 8'h0C, 8'(n_rd - c1));
    $display("test selected board done");
    c0 = n_rst;
    access(1'b0, 8'hC6, 8'h00, 1'b0);
    chk("reset read", 8'h0F, rd);
    chk("reset pulse", 8'h01, 8'(n_rst - c0));
    chk("deselected", 8'h00, {7'h0, selected});
    chk("data cleared", 8'h00, out_data);
    access(1'b1, 8'hCA, 8'h05, 1'b0);
    access(1'b1, 8'hCC, 8'h0A, 1'b0);
    chk("no first phase", 8'h00, {7'h0, selected});
    select(8'h01, 8'h06, 8'h0A);
    chk("broken chain", 8'h00, {7'h0, selected});
    access(1'b0, 8'hC0, 8'h00, 1'b0);
    chk("absent read", 8'h0F, rd);
    $display("test chain done");
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? 8'h0B : ((i == 1) ? 8'h0C : byte_t'($urandom));
      access(1'b1, 8'hC8, wd, 1'b0);
      chk("wide mode", {7'h0, wide_exp(wd[3:0])}, {7'h0, wide_mode});
    end
    $display("test categories done");
    attn_req = 1'b1;
    repeat (3) @(negedge clk);
    chk("attention line", 8'h00, {7'h0, bus_if.attention_n});
    chk("irq raised", 8'h01, {7'h0, irq});
    attn_req = 1'b0;
    repeat (3) @(negedge clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    $display("test attention done");
    give_verdict();
  end
endmodule
